// *** core/fps_seq_top.sv ***
module fps_seq_top
    import fps_pkg::*;
(
    input  wire logic                  sys_clk,
    input  wire logic                  rst,
    input  wire logic                  operand_load_timing_select,
    input  wire logic [2:0]            pipeline_register_enables,
    input  wire logic                  constant_reg_load_enable_n,
    input  wire logic                  first_input_reg_load_enable_n,
    input  wire logic                  second_input_reg_load_enable_n,
    input  wire logic [FPS_HALF_W-1:0] da_bus,
    input  wire logic [FPS_HALF_W-1:0] db_bus,
    input  wire logic [FPS_INS_W-1:0]  ins_bus,
    input  wire logic                  first_is_dp,
    input  wire logic                  second_is_dp,
    output logic [FPS_WORD_W-1:0]      y_bus,
    output logic                       y_valid,
    output logic                       load_blocked
);
    fps_res_if ex ();

    fps_exec u_exec (
        .sys_clk    (sys_clk),
        .rst        (rst),
        .extra_pipe (pipeline_register_enables == FPS_PIPES_ALL),
        .ex         (ex)
    );

    logic [FPS_WORD_W-1:0] first_operand_register, second_operand_register;
    logic [FPS_WORD_W-1:0] product_result_register, sum_result_register;
    logic [FPS_WORD_W-1:0] constant_holding_register;
    logic [FPS_WORD_W-1:0] next_ra, next_rb, next_pr, next_sr, next_cr;
    logic [FPS_HALF_W-1:0] upa, upb, next_upa, next_upb;
    logic [FPS_INS_W-1:0]  ins_reg, next_ins_reg;
    fps_ld_state_t         ld, next_ld;
    logic                  go, next_go, mixed_dp, next_mixed_dp, blk, next_blk;
    logic                  last_dp_mul, next_last_dp_mul;
    logic [FPS_WORD_W-1:0] yq, next_yq;
    logic                  yv, next_yv;
    logic [1:0]            hold, next_hold;
    logic                  op_dp;

    // dp when either operand is dp; feedback-selected operands are treated the same way
    assign op_dp = first_is_dp | second_is_dp | ins_bus[FPS_BIT_FBA] | ins_bus[FPS_BIT_FBB];

    always_comb begin
        next_ra         = first_operand_register;
        next_rb         = second_operand_register;
        next_upa        = upa;
        next_upb        = upb;
        next_ins_reg    = ins_reg;
        next_ld         = ld;
        next_go         = 1'b0;
        next_mixed_dp   = mixed_dp;
        next_blk        = 1'b0;
        next_last_dp_mul = last_dp_mul;
        next_cr         = constant_holding_register;
        // constant register loads on the same clock edge as everything else
        if (!constant_reg_load_enable_n) begin
            next_cr = sum_result_register;
        end
        case (ld)
            FPS_LD_OPEN: begin
                // not entered on the usual path; falls back to idle
                next_blk = 1'b0;
                next_ld  = FPS_LD_IDLE;
            end
            FPS_LD_UPPER: begin
                // lower half completes the pair
                if (!first_input_reg_load_enable_n) begin
                    next_ra = {upa, da_bus};
                end
                if (!second_input_reg_load_enable_n) begin
                    next_rb = {upb, db_bus};
                end
                next_go = 1'b1;
                next_ld = FPS_LD_IDLE;
            end
            FPS_LD_IDLE: begin
                if (last_dp_mul && !op_dp && ins_bus != FPS_NOP_WORD) begin
                    // this edge is the open cycle: op refused, next edge loads
                    next_blk         = 1'b1;
                    next_last_dp_mul = 1'b0;
                end else if (ins_bus == FPS_NOP_WORD) begin
                    next_ins_reg     = ins_bus; // nothing starts
                    next_last_dp_mul = 1'b0;
                end else begin
                    next_ins_reg     = ins_bus;
                    next_mixed_dp    = op_dp;
                    next_last_dp_mul = op_dp & ins_bus[FPS_BIT_MUL];
                    if (operand_load_timing_select || !op_dp) begin
                        // whole pair taken in one clock
                        if (!first_input_reg_load_enable_n) begin
                            next_ra = op_dp ? {da_bus, db_bus} : {da_bus, 32'h0};
                        end
                        if (!second_input_reg_load_enable_n) begin
                            next_rb = op_dp ? {db_bus, da_bus} : {db_bus, 32'h0};
                        end
                        next_go = 1'b1;
                    end else begin
                        next_upa = da_bus; // upper half first
                        next_upb = db_bus;
                        next_ld  = FPS_LD_UPPER;
                    end
                end
            end
            default: next_ld = FPS_LD_IDLE;
        endcase
    end

    // chained operands: sum register plus product register, or constant register for a multiply without fba; always dp
    always_comb begin
        ex.start  = go;
        ex.is_mul = ins_reg[FPS_BIT_MUL];
        ex.is_dp  = mixed_dp | ins_reg[FPS_BIT_CHAIN];
        ex.a      = first_operand_register;
        ex.b      = second_operand_register;
        if (ins_reg[FPS_BIT_CHAIN]) begin
            ex.a = ins_reg[FPS_BIT_MUL] ? constant_holding_register : product_result_register;
            if (ins_reg[FPS_BIT_FBA]) begin
                ex.a = product_result_register;
            end
            ex.b = sum_result_register;
        end
    end

    always_comb begin
        next_pr = product_result_register;
        next_sr = sum_result_register;
        if (ex.done && ex.done_mul) begin
            next_pr = ex.result;
        end
        if (ex.done && !ex.done_mul) begin
            next_sr = ex.result;
        end
    end

    // output hold: dp result stands two cycles only before a like dp op, else one;
    // with load mode 1 and all pipes on, only dp mul after dp mul
    always_comb begin
        next_yq   = yq;
        next_yv   = 1'b0;
        next_hold = 2'h0;
        if (ex.done) begin
            next_yq   = ex.result;
            next_yv   = 1'b1;
            if (!ex.done_dp) begin
                next_hold = 2'h1; // sp may stay if next slot is empty
            end else if (operand_load_timing_select
                         && pipeline_register_enables == FPS_PIPES_ALL) begin
                next_hold = {1'b0, ex.done_mul & last_dp_mul};
            end else begin
                // a following nop is no like function, so the result stands one cycle
                next_hold = {1'b0, (ins_reg != FPS_NOP_WORD)
                                   & (ins_reg[FPS_BIT_MUL] == ex.done_mul) & mixed_dp};
            end
        end else if (hold != 2'h0) begin
            next_yv   = 1'b1;
            next_hold = 2'h0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            first_operand_register    <= FPS_WORD_RST;
            second_operand_register   <= FPS_WORD_RST;
            product_result_register   <= FPS_WORD_RST;
            sum_result_register       <= FPS_WORD_RST;
            constant_holding_register <= FPS_WORD_RST;
            upa                       <= 32'h0;
            upb                       <= 32'h0;
            ins_reg                   <= FPS_NOP_WORD;
            ld                        <= FPS_LD_IDLE;
            go                        <= 1'b0;
            mixed_dp                  <= 1'b0;
            blk                       <= 1'b0;
            last_dp_mul               <= 1'b0;
            yq                        <= FPS_WORD_RST;
            yv                        <= 1'b0;
            hold                      <= 2'h0;
        end else begin
            first_operand_register    <= next_ra;
            second_operand_register   <= next_rb;
            product_result_register   <= next_pr;
            sum_result_register       <= next_sr;
            constant_holding_register <= next_cr;
            upa                       <= next_upa;
            upb                       <= next_upb;
            ins_reg                   <= next_ins_reg;
            ld                        <= next_ld;
            go                        <= next_go;
            mixed_dp                  <= next_mixed_dp;
            blk                       <= next_blk;
            last_dp_mul               <= next_last_dp_mul;
            yq                        <= next_yq;
            yv                        <= next_yv;
            hold                      <= next_hold;
        end
    end

    // chained pos step: instruction, nop, result = three clocks
    assign y_bus        = yq;
    assign y_valid      = yv;
    assign load_blocked = blk;
endmodule : fps_seq_top

// *** core/fps_pkg.sv ***
// Behaviour
// - chained steps feed current sum and latest product back to multiplier.
// - product-of-sums step takes three clocks; sum-of-products step takes two.
// - no-operation word is 01100000000; nothing new starts when registered.
// - operands of differing precision run as a double-precision operation.
// - operands fed back from internal result registers count as double precision.
// - mixed-precision operations have exactly double-precision latency and timing.
// - single/double format conversions are mixed-precision with double timing.
// - double result held two cycles only before a like double function.
// - during the open cycle after double multiply, no single-precision op is loaded.
// - a single-precision multiply completes in one clock.
// - single result stays two cycles when next operation outputs nothing next.
// - load mode 1, all pipes enabled: double result two cycles only mul-after-mul.
// - with load timing high a full operand pair loads in one clock.
// - enabled extra pipeline registers delay every result by one cycle.
package fps_pkg;
    localparam int          FPS_INS_W      = 11;
    localparam int          FPS_HALF_W     = 32;
    localparam int          FPS_WORD_W     = 64;
    localparam logic [10:0] FPS_NOP_WORD   = 11'h300;
    // instruction fields: bit 10 chained, bit 9 multiply, bits 8:7 feedback select
    localparam int          FPS_BIT_CHAIN  = 10;
    localparam int          FPS_BIT_MUL    = 9;
    localparam int          FPS_BIT_FBA    = 8;
    localparam int          FPS_BIT_FBB    = 7;
    localparam int          FPS_DP_LAT     = 2;
    localparam int          FPS_SP_LAT     = 1;
    localparam int          FPS_POS_STEP   = 3;
    localparam int          FPS_SOP_STEP   = 2;
    localparam logic [63:0] FPS_WORD_RST   = 64'h0;
    localparam logic [2:0]  FPS_PIPES_ALL  = 3'h0;

    typedef enum logic [1:0] {
        FPS_LD_IDLE  = 2'h0,
        FPS_LD_UPPER = 2'h1,
        FPS_LD_OPEN  = 2'h3
    } fps_ld_state_t;
endpackage : fps_pkg

// *** core/fps_res_if.sv ***
interface fps_res_if;
    import fps_pkg::*;
    logic                  start;
    logic                  is_mul;
    logic                  is_dp;
    logic [FPS_WORD_W-1:0] a;
    logic [FPS_WORD_W-1:0] b;
    logic                  done;
    logic                  done_mul;
    logic                  done_dp;
    logic [FPS_WORD_W-1:0] result;
    modport ctl (output start, is_mul, is_dp, a, b, input done, done_mul, done_dp, result);
    modport exe (input start, is_mul, is_dp, a, b, output done, done_mul, done_dp, result);
endinterface : fps_res_if

// *** core/fps_exec.sv ***
// latency unit: sp op finishes in one clock, dp/mixed in two, extra pipe adds one
module fps_exec
    import fps_pkg::*;
(
    input  wire logic sys_clk,
    input  wire logic rst,
    input  wire logic extra_pipe,
    fps_res_if.exe    ex
);
    logic [FPS_WORD_W-1:0] st1_r, st2_r, next_st1_r, next_st2_r, res, next_res;
    logic [FPS_WORD_W-1:0] st3_r, next_st3_r;
    logic [2:0]            v1, v2, next_v1, next_v2; // valid, mul, dp
    logic [2:0]            v3, next_v3;
    logic                  dn, next_dn, dm, next_dm, dd, next_dd;

    always_comb begin
        next_st1_r = ex.is_mul ? ex.a * ex.b : ex.a + ex.b;
        next_v1    = {ex.start, ex.is_mul, ex.is_dp};
        next_st2_r = st1_r;
        next_v2    = v1[2] && v1[0] ? v1 : 3'h0;
        // sp result leaves after stage one, dp after stage two
        next_dn    = v2[2] | (v1[2] & ~v1[0]);
        next_dm    = v2[2] ? v2[1] : v1[1];
        next_dd    = v2[2];
        next_res   = v2[2] ? st2_r : st1_r;
        next_st3_r = st2_r;
        next_v3    = 3'h0;
        // one added register stage for sp and dp alike
        if (extra_pipe) begin
            next_v2  = v1;
            next_v3  = v2[2] && v2[0] ? v2 : 3'h0;
            next_dn  = v3[2] | (v2[2] & ~v2[0]);
            next_dm  = v3[2] ? v3[1] : v2[1];
            next_dd  = v3[2];
            next_res = v3[2] ? st3_r : st2_r;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            st1_r <= FPS_WORD_RST;
            st2_r <= FPS_WORD_RST;
            st3_r <= FPS_WORD_RST;
            res   <= FPS_WORD_RST;
            v1    <= 3'h0;
            v2    <= 3'h0;
            v3    <= 3'h0;
            dn    <= 1'b0;
            dm    <= 1'b0;
            dd    <= 1'b0;
        end else begin
            st1_r <= next_st1_r;
            st2_r <= next_st2_r;
            st3_r <= next_st3_r;
            res   <= next_res;
            v1    <= next_v1;
            v2    <= next_v2;
            v3    <= next_v3;
            dn    <= next_dn;
            dm    <= next_dm;
            dd    <= next_dd;
        end
    end

    assign ex.done     = dn;
    assign ex.done_mul = dm;
    assign ex.done_dp  = dd;
    assign ex.result   = res;
endmodule : fps_exec

// *** tb/fps_seq_monitor.sv ***
module fps_seq_monitor
    import fps_pkg::*;
(
    input wire logic        sys_clk,
    input wire logic        rst,
    input wire logic        operand_load_timing_select,
    input wire logic [2:0]  pipeline_register_enables,
    input wire logic [10:0] ins_bus,
    input wire logic        first_is_dp,
    input wire logic        second_is_dp,
    input wire logic        y_valid,
    input wire logic        load_blocked
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] idle_cnt;
    logic [3:0] next_idle_cnt;
    logic       op;
    logic       m1;
    logic       quiet;
    logic       pipe_on;
    logic       sp_op;
    logic       dp_op;
    logic       mixed;
    logic       dp_mul;
    assign op      = ins_bus != FPS_NOP_WORD;
    assign m1      = operand_load_timing_select;
    assign quiet   = idle_cnt >= 4'ha;
    assign pipe_on = pipeline_register_enables == FPS_PIPES_ALL;
    assign sp_op   = op && !first_is_dp && !second_is_dp && ins_bus[8:7] == 2'h0;
    assign dp_op   = op && first_is_dp && second_is_dp;
    assign mixed   = op && (first_is_dp != second_is_dp);
    assign dp_mul  = dp_op && ins_bus[FPS_BIT_MUL];
    // counts nop cycles so latency checks start from a drained pipe
    always_comb begin
        next_idle_cnt = idle_cnt;
        if (op)
            next_idle_cnt = 4'h0;
        else if (idle_cnt != 4'hf)
            next_idle_cnt = idle_cnt + 4'h1;
    end
    always_ff @(posedge sys_clk) begin
        if (rst)
            idle_cnt <= 4'hf;
        else
            idle_cnt <= next_idle_cnt;
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    sequence s_sp_q;
        quiet && m1 && sp_op;
    endsequence
    sequence s_open_cycle;
        m1 && dp_mul ##1 sp_op;
    endsequence
    a_sp_hold_two: assert property (s_sp_q ##0 !pipe_on ##1 !op
        |-> ##2 !y_valid ##1 y_valid [*2] ##1 !y_valid) else $error("sp result timing wrong");
    a_extra_pipe_delay: assert property (s_sp_q ##0 pipe_on |-> ##5 $rose(y_valid))
        else $error("extra pipe stage latency wrong");
    a_mixed_dp_latency: assert property (quiet && m1 && mixed && !pipe_on
        |-> ##5 $rose(y_valid)) else $error("mixed precision latency wrong");
    a_dp_hold_one: assert property (quiet && m1 && dp_op && !pipe_on ##1 !op
        |-> ##3 !y_valid ##1 y_valid ##1 !y_valid) else $error("dp result hold wrong");
    a_two_half_load: assert property (quiet && !m1 && dp_op && !pipe_on
        |-> ##6 $rose(y_valid)) else $error("two-half dp latency wrong");
    a_nop_no_result: assert property (quiet && !op ##1 !op |-> !y_valid [*5])
        else $error("result after nop");
    a_open_cycle_block: assert property (s_open_cycle |=> load_blocked)
        else $error("open cycle not blocked");
    a_block_single: assert property (load_blocked |=> !load_blocked)
        else $error("block longer than one cycle");
    a_block_cause: assert property ($rose(load_blocked) |-> $past(dp_mul, 2))
        else $error("block without dp multiply");
endmodule : fps_seq_monitor

bind fps_seq_top fps_seq_monitor fps_seq_monitor_i (
    .sys_clk(sys_clk), .rst(rst), .ins_bus(ins_bus), .y_valid(y_valid),
    .operand_load_timing_select(operand_load_timing_select),
    .pipeline_register_enables(pipeline_register_enables),
    .first_is_dp(first_is_dp), .second_is_dp(second_is_dp), .load_blocked(load_blocked)
);

// *** tb/fps_ctl_model.sv ***
module fps_ctl_model
    import fps_pkg::*;
(
    input  wire logic             sys_clk,
    input  wire logic             mode,
    output logic [FPS_HALF_W-1:0] da_bus,
    output logic [FPS_HALF_W-1:0] db_bus,
    output logic [FPS_INS_W-1:0]  ins_bus,
    output logic                  first_is_dp,
    output logic                  second_is_dp
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        da_bus = 32'h0;
        db_bus = 32'h0;
        ins_bus = FPS_NOP_WORD;
        first_is_dp = 1'b0;
        second_is_dp = 1'b0;
    end
    // called at a falling edge; dp in mode 0 spends two clocks on the halves
    task automatic send(input logic [10:0] op, input logic [1:0] prec,
                        input logic [63:0] a, input logic [63:0] b);
        ins_bus <= op;
        {first_is_dp, second_is_dp} <= prec;
        da_bus <= a[63:32];
        db_bus <= b[63:32];
        if (!mode && (|prec)) begin
            @(negedge sys_clk);
            da_bus <= a[31:0];
            db_bus <= b[31:0];
        end
    endtask : send
    // released data lines flip so a stale value never looks valid
    task automatic idle(input int n);
        repeat (n) begin
            @(negedge sys_clk);
            ins_bus <= FPS_NOP_WORD;
            da_bus <= ~da_bus;
            db_bus <= ~db_bus;
        end
    endtask : idle
endmodule : fps_ctl_model

// *** tb/test_fpu_op_sequencing_timing.sv ***
module test_fpu_op_sequencing_timing
    import fps_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [63:0] OPA = 64'h3ff0_0000_4000_0000;
    localparam logic [63:0] OPB = 64'h4008_0000_3f80_0000;
    logic                  sys_clk;
    logic                  rst = 1'b1;
    logic                  mode = 1'b1;
    logic [2:0]            pipes = 3'h6;
    logic [FPS_HALF_W-1:0] da_bus;
    logic [FPS_HALF_W-1:0] db_bus;
    logic [FPS_INS_W-1:0]  ins_bus;
    logic                  first_is_dp;
    logic                  second_is_dp;
    logic [FPS_WORD_W-1:0] y_bus;
    logic                  y_valid;
    logic                  load_blocked;
    int                    fails = 0;
    int                    n_compared = 0;
    int                    cycles = 0;
    int                    first;
    int                    len;
    int                    blk;
    fps_ctl_model fps_ctl_model_i (
        .sys_clk(sys_clk), .mode(mode), .da_bus(da_bus), .db_bus(db_bus),
        .ins_bus(ins_bus), .first_is_dp(first_is_dp), .second_is_dp(second_is_dp)
    );
    fps_seq_top fps_seq_top_i (
        .sys_clk(sys_clk), .rst(rst), .operand_load_timing_select(mode),
        .pipeline_register_enables(pipes), .constant_reg_load_enable_n(1'b0),
        .first_input_reg_load_enable_n(1'b0), .second_input_reg_load_enable_n(1'b0),
        .da_bus(da_bus), .db_bus(db_bus), .ins_bus(ins_bus), .first_is_dp(first_is_dp),
        .second_is_dp(second_is_dp), .y_bus(y_bus), .y_valid(y_valid),
        .load_blocked(load_blocked)
    );
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 1000) begin
            fails = fails + 1;
            tally_and_finish();
        end
    end
    task automatic check(input string what, input int exp, input int got);
        n_compared++;
        if (got != exp) begin
            fails++;
            $display("unexpected %s: expected %0d, seen %0d", what, exp, got);
        end
    endtask : check
    task automatic check_word(input string what, input logic [63:0] exp,
                              input logic [63:0] got);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : check_word
    task automatic watch();
        first = 0;
        len = 0;
        blk = 0;
        repeat (18) begin
            @(negedge sys_clk);
            if (y_valid === 1'b1 && first == 0)
                first = cycles;
            if (y_valid === 1'b1)
                len++;
            if (load_blocked === 1'b1)
                blk++;
        end
    endtask : watch
    // issued at a falling edge; latency counts from the taking edge
    task automatic run_op(input string what, input logic [10:0] op, input logic [1:0] prec,
                          input int lat, input int hold);
        int t0;
        t0 = cycles + 1;
        fork
            begin
                fps_ctl_model_i.send(op, prec, OPA, OPB);
                fps_ctl_model_i.idle(16);
            end
            watch();
        join
        check({what, " latency"}, lat, first == 0 ? 0 : first - t0);
        check({what, " length"}, hold, len);
        $display("test %s done", what);
    endtask : run_op
    task automatic tally_and_finish();
        $display("compared %0d, mismatched %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : tally_and_finish
    initial begin
        repeat (16) @(posedge sys_clk);
        @(negedge sys_clk);
        rst = 1'b0;
        check("valid after reset", 0, int'(y_valid === 1'b1));
        run_op("sp multiply", 11'h200, 2'h0, 3, 2);
        run_op("mixed add", 11'h000, 2'h2, 4, 1);
        run_op("mixed multiply", 11'h200, 2'h1, 4, 1);
        run_op("feedback operand", 11'h100, 2'h0, 4, 1);
        run_op("dp add", 11'h000, 2'h3, 4, 1);
        check_word("dp add sum", 64'h7ff8_0000_7ff8_0000, y_bus);
        run_op("chained sum", 11'h400, 2'h3, 4, 1);
        check_word("chained sum", 64'h8ff5_ff80_7ff8_0000, y_bus);
        run_op("nop", FPS_NOP_WORD, 2'h3, 0, 0);
        pipes = FPS_PIPES_ALL;
        run_op("sp with pipes", 11'h200, 2'h0, 4, 2);
        run_op("dp with pipes", 11'h000, 2'h3, 5, 1);
        pipes = 3'h6;
        mode = 1'b0;
        run_op("two-half dp add", 11'h000, 2'h3, 5, 1);
        mode = 1'b1;
        fork
            begin
                fps_ctl_model_i.send(11'h200, 2'h3, OPA, OPB);
                @(negedge sys_clk);
                fps_ctl_model_i.send(11'h200, 2'h0, OPA, OPB);
                @(negedge sys_clk);
                fps_ctl_model_i.send(11'h200, 2'h0, OPA, OPB);
                fps_ctl_model_i.idle(14);
            end
            watch();
        join
        check("open cycle refusals", 1, blk);
        check("results after refusal", 3, len);
        $display("test open cycle done");
        tally_and_finish();
    end
endmodule : test_fpu_op_sequencing_timing
